// >>> pkg/alrm_pkg.sv
// shared constants, register map and types for the alarm and relay block
package alrm_pkg;
  localparam int NUM_IN = 4;
  localparam int NUM_RLY = 2;
  localparam int RD_W = 32;
  // readings and setpoints in units of 0.0001 K
  localparam logic [31:0] DEF_LOW_SP = 32'h0000_0000;
  localparam logic [31:0] DEF_HIGH_SP = 32'h0098_9680;
  localparam logic [31:0] DEF_DBAND = 32'h0000_2710;
  // flash half period in nanoseconds, converted to clock cycles
  localparam int FLASH_HALF_NS = 250000000;
  localparam int CLK_NS = 10;
  localparam int FLASH_HALF_CYC = FLASH_HALF_NS / CLK_NS;
  // register map, byte offsets; per-input block every 0x20
  localparam logic [11:0] OFF_IN_BASE = 12'h000;
  localparam logic [11:0] IN_STRIDE = 12'h020;
  localparam logic [4:0] SUB_CTRL = 5'h00;
  localparam logic [4:0] SUB_LOW = 5'h04;
  localparam logic [4:0] SUB_HIGH = 5'h08;
  localparam logic [4:0] SUB_DBAND = 5'h0c;
  localparam logic [4:0] SUB_READ = 5'h10;
  localparam logic [11:0] OFF_RLY1 = 12'h100;
  localparam logic [11:0] OFF_RLY2 = 12'h104;
  localparam logic [11:0] OFF_STATUS = 12'h108;
  localparam logic [11:0] OFF_CLEAR = 12'h10c;
  // input control fields
  localparam int CB_EN = 0;
  localparam int CB_VIS = 1;
  localparam int CB_AUD = 2;
  localparam int CB_LATCH = 3;
  localparam logic [3:0] DEF_CTRL = 4'h6;
  typedef enum logic [1:0] {ALRM_R_OFF, ALRM_R_ON, ALRM_R_ALARM} alrm_rmode_t;
  typedef enum logic [1:0] {ALRM_F_LOW, ALRM_F_HIGH, ALRM_F_BOTH} alrm_follow_t;
  typedef struct packed {
    alrm_follow_t follow;
    logic [1:0] sel;
    alrm_rmode_t mode;
  } alrm_rcfg_t;
  localparam alrm_rcfg_t DEF_RCFG = '{follow: ALRM_F_BOTH, sel: 2'h0, mode: ALRM_R_OFF};
  typedef struct packed {
    logic [31:0] low;
    logic [31:0] high;
    logic [31:0] dband;
    logic [3:0] ctrl;
  } alrm_icfg_t;
endpackage

// >>> core/alrm_eval.sv
// per-input high and low comparison with dead band and latching
`timescale 1ns/1ns
module alrm_eval (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // reading and settings
  input wire logic [31:0] reading,
  input wire alrm_pkg::alrm_icfg_t cfg,
  input wire logic clear_latch,
  // alarm states
  output logic high_act,
  output logic low_act
);
  logic high_reg;
  logic low_reg;
  logic high_next;
  logic low_next;
  wire logic en = cfg.ctrl[alrm_pkg::CB_EN];
  wire logic latch = cfg.ctrl[alrm_pkg::CB_LATCH];
  wire logic [32:0] high_rel = {1'b0, cfg.high} - {1'b0, cfg.dband};
  wire logic [32:0] low_rel = {1'b0, cfg.low} + {1'b0, cfg.dband};
  wire logic high_trip = reading > cfg.high;
  wire logic low_trip = reading < cfg.low;
  wire logic high_stay = high_rel[32] ? 1'b1 : ({1'b0, reading} > high_rel);
  wire logic low_stay = {1'b0, reading} < low_rel;
  // set wins over the reset-alarm command so a fresh trip is never lost
  assign high_next = !en ? 1'b0 :
    high_trip ? 1'b1 :
    (latch && !clear_latch) ? high_reg :
    (high_reg && high_stay);
  assign low_next = !en ? 1'b0 :
    low_trip ? 1'b1 :
    (latch && !clear_latch) ? low_reg :
    (low_reg && low_stay);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_reg <= 1'b0;
      low_reg <= 1'b0;
    end else begin
      high_reg <= high_next;
      low_reg <= low_next;
    end
  end
  assign high_act = high_reg;
  assign low_act = low_reg;
endmodule

// >>> core/alrm_relay.sv
// alarm evaluation for four inputs, indicators and two relays behind AHB-Lite
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ns
module alrm_relay #(
  parameter int FLASH_HALF = alrm_pkg::FLASH_HALF_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // operator and display
  input wire logic reset_alarm,
  input wire logic [1:0] shown_input,
  output logic show_alarm_msg,
  // front panel and relays
  output logic indicator,
  output logic beeper,
  output logic [1:0] relay_drive
);
  localparam int NI = alrm_pkg::NUM_IN;
  localparam int NR = alrm_pkg::NUM_RLY;
  localparam int FC_W = $clog2(FLASH_HALF + 1);

  alrm_pkg::alrm_icfg_t icfg_reg [NI];
  logic [31:0] reading_reg [NI];
  alrm_pkg::alrm_rcfg_t rcfg_reg [NR];
  logic [NI-1:0] high_act;
  logic [NI-1:0] low_act;
  logic [FC_W-1:0] flash_cnt_reg;
  logic flash_reg;
  logic ind_reg;
  logic beep_reg;
  logic [1:0] relay_reg;
  logic show_reg;
  logic clear_reg;
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic [1:0] sh_s1_reg;
  logic [1:0] sh_s2_reg;

  // bus address phase capture
  logic wr_pend_reg;
  logic [11:0] addr_reg;
  logic [31:0] rdata_reg;
  wire logic take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  function automatic logic [2:0] in_index(input logic [11:0] a);
    // only the four input blocks decode; the gap below the relay words must not alias
    in_index = (a < 12'(alrm_pkg::NUM_IN * alrm_pkg::IN_STRIDE)) ? {1'b0, a[6:5]} : 3'h4;
  endfunction

  // pin synchronisers for operator inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
      sh_s1_reg <= 2'h0;
      sh_s2_reg <= 2'h0;
    end else begin
      rst_s1_reg <= reset_alarm;
      rst_s2_reg <= rst_s1_reg;
      sh_s1_reg <= shown_input;
      sh_s2_reg <= sh_s1_reg;
    end
  end

  wire logic [2:0] wr_idx = in_index(addr_reg);
  wire logic [4:0] wr_sub = addr_reg[4:0];
  wire logic wr_clear = wr_pend_reg && addr_reg == alrm_pkg::OFF_CLEAR;
  wire logic clear_cmd = rst_s2_reg || (wr_clear && hwdata[0]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
      clear_reg <= 1'b0;
    end else begin
      wr_pend_reg <= take && hwrite;
      if (take) begin
        addr_reg <= haddr;
      end
      clear_reg <= clear_cmd;
    end
  end

  // per-input settings and evaluation
  genvar gi;
  generate
    for (gi = 0; gi < NI; gi++) begin : g_in
      wire logic hit = wr_pend_reg && wr_idx == 3'(gi);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          icfg_reg[gi] <= '{low: alrm_pkg::DEF_LOW_SP, high: alrm_pkg::DEF_HIGH_SP,
                            dband: alrm_pkg::DEF_DBAND, ctrl: alrm_pkg::DEF_CTRL};
          reading_reg[gi] <= 32'h0000_0000;
        end else if (hit) begin
          if (wr_sub == alrm_pkg::SUB_CTRL) begin
            icfg_reg[gi].ctrl <= hwdata[3:0];
          end else if (wr_sub == alrm_pkg::SUB_LOW) begin
            icfg_reg[gi].low <= hwdata;
          end else if (wr_sub == alrm_pkg::SUB_HIGH) begin
            icfg_reg[gi].high <= hwdata;
          end else if (wr_sub == alrm_pkg::SUB_DBAND) begin
            icfg_reg[gi].dband <= hwdata;
          end else if (wr_sub == alrm_pkg::SUB_READ) begin
            reading_reg[gi] <= hwdata;
          end
        end
      end
      alrm_eval u_eval (
        .hclk(hclk),
        .hresetn(hresetn),
        .reading(reading_reg[gi]),
        .cfg(icfg_reg[gi]),
        .clear_latch(clear_reg),
        .high_act(high_act[gi]),
        .low_act(low_act[gi])
      );
    end
  endgenerate

  // relay configuration and drive
  genvar gr;
  generate
    for (gr = 0; gr < NR; gr++) begin : g_rly
      wire logic [11:0] roff = (gr == 0) ? alrm_pkg::OFF_RLY1 : alrm_pkg::OFF_RLY2;
      wire logic hi = high_act[rcfg_reg[gr].sel];
      wire logic lo = low_act[rcfg_reg[gr].sel];
      wire logic fol = (rcfg_reg[gr].follow == alrm_pkg::ALRM_F_LOW) ? lo :
        (rcfg_reg[gr].follow == alrm_pkg::ALRM_F_HIGH) ? hi :
        (lo || hi);
      wire logic drv = (rcfg_reg[gr].mode == alrm_pkg::ALRM_R_ON) ? 1'b1 :
        (rcfg_reg[gr].mode == alrm_pkg::ALRM_R_ALARM) ? fol : 1'b0;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rcfg_reg[gr] <= alrm_pkg::DEF_RCFG;
          relay_reg[gr] <= 1'b0;
        end else begin
          if (wr_pend_reg && addr_reg == roff) begin
            rcfg_reg[gr] <= alrm_pkg::alrm_rcfg_t'(hwdata[5:0]);
          end
          relay_reg[gr] <= drv;
        end
      end
    end
  endgenerate
  assign relay_drive = relay_reg;

  // indicator, beeper and display alternation
  logic [NI-1:0] vis_en;
  logic [NI-1:0] aud_en;
  logic [NI-1:0] any_act;
  generate
    for (gi = 0; gi < NI; gi++) begin : g_opt
      assign vis_en[gi] = icfg_reg[gi].ctrl[alrm_pkg::CB_EN] && icfg_reg[gi].ctrl[alrm_pkg::CB_VIS];
      assign aud_en[gi] = icfg_reg[gi].ctrl[alrm_pkg::CB_EN] && icfg_reg[gi].ctrl[alrm_pkg::CB_AUD];
      assign any_act[gi] = high_act[gi] || low_act[gi];
    end
  endgenerate
  wire logic vis_active = |(vis_en & any_act);
  wire logic ind_next = vis_active ? flash_reg : |vis_en;
  wire logic beep_next = |(aud_en & any_act);
  // same flash phase as the indicator so message and panel blink together
  wire logic show_next = any_act[sh_s2_reg] && flash_reg;
  wire logic flash_wrap = flash_cnt_reg == FC_W'(FLASH_HALF - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_cnt_reg <= '0;
      flash_reg <= 1'b0;
      ind_reg <= 1'b0;
      beep_reg <= 1'b0;
      show_reg <= 1'b0;
    end else begin
      flash_cnt_reg <= flash_wrap ? '0 : flash_cnt_reg + 1'b1;
      flash_reg <= flash_wrap ? !flash_reg : flash_reg;
      ind_reg <= ind_next;
      beep_reg <= beep_next;
      show_reg <= show_next;
    end
  end
  assign indicator = ind_reg;
  assign beeper = beep_reg;
  assign show_alarm_msg = show_reg;

  // read data, registered at the address phase
  logic [31:0] rd_val;
  wire logic [2:0] rd_idx = in_index(haddr);
  wire logic [4:0] rd_sub = haddr[4:0];
  always_comb begin
    rd_val = 32'h0000_0000;
    if (rd_idx < 3'h4) begin
      if (rd_sub == alrm_pkg::SUB_CTRL) begin
        rd_val = {28'h0000000, icfg_reg[rd_idx[1:0]].ctrl};
      end else if (rd_sub == alrm_pkg::SUB_LOW) begin
        rd_val = icfg_reg[rd_idx[1:0]].low;
      end else if (rd_sub == alrm_pkg::SUB_HIGH) begin
        rd_val = icfg_reg[rd_idx[1:0]].high;
      end else if (rd_sub == alrm_pkg::SUB_DBAND) begin
        rd_val = icfg_reg[rd_idx[1:0]].dband;
      end else if (rd_sub == alrm_pkg::SUB_READ) begin
        rd_val = reading_reg[rd_idx[1:0]];
      end
    end else if (haddr == alrm_pkg::OFF_RLY1) begin
      rd_val = {26'h0000000, rcfg_reg[0]};
    end else if (haddr == alrm_pkg::OFF_RLY2) begin
      rd_val = {26'h0000000, rcfg_reg[1]};
    end else if (haddr == alrm_pkg::OFF_STATUS) begin
      rd_val = {20'h00000, beep_reg, ind_reg, relay_reg, high_act, low_act};
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      rdata_reg <= rd_val;
    end
  end

  // checks
  property p_off_relay;
    @(posedge hclk) disable iff (!hresetn)
      rcfg_reg[0].mode == alrm_pkg::ALRM_R_OFF |=> !relay_reg[0];
  endproperty
  a_off_relay: assert property (p_off_relay) else $error("relay1 on in off mode");
  property p_on_relay;
    @(posedge hclk) disable iff (!hresetn)
      rcfg_reg[1].mode == alrm_pkg::ALRM_R_ON |=> relay_reg[1];
  endproperty
  a_on_relay: assert property (p_on_relay) else $error("relay2 off in on mode");
  property p_follow_low;
    @(posedge hclk) disable iff (!hresetn)
      rcfg_reg[0].mode == alrm_pkg::ALRM_R_ALARM && rcfg_reg[0].follow == alrm_pkg::ALRM_F_LOW
      |=> relay_reg[0] == $past(low_act[rcfg_reg[0].sel]);
  endproperty
  a_follow_low: assert property (p_follow_low) else $error("relay1 not following low");
  property p_follow_both;
    @(posedge hclk) disable iff (!hresetn)
      rcfg_reg[0].mode == alrm_pkg::ALRM_R_ALARM && rcfg_reg[0].follow == alrm_pkg::ALRM_F_BOTH
      && any_act[rcfg_reg[0].sel] |=> relay_reg[0];
  endproperty
  a_follow_both: assert property (p_follow_both) else $error("relay1 missed alarm");
  property p_disabled;
    @(posedge hclk) disable iff (!hresetn)
      !icfg_reg[0].ctrl[alrm_pkg::CB_EN] |=> !high_act[0] && !low_act[0];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled input in alarm");
  property p_high_trip;
    @(posedge hclk) disable iff (!hresetn)
      icfg_reg[0].ctrl[alrm_pkg::CB_EN] && reading_reg[0] > icfg_reg[0].high |=> high_act[0];
  endproperty
  a_high_trip: assert property (p_high_trip) else $error("high alarm missed");
  property p_low_trip;
    @(posedge hclk) disable iff (!hresetn)
      icfg_reg[0].ctrl[alrm_pkg::CB_EN] && reading_reg[0] < icfg_reg[0].low |=> low_act[0];
  endproperty
  a_low_trip: assert property (p_low_trip) else $error("low alarm missed");
  sequence s_latched_quiet;
    icfg_reg[0].ctrl[alrm_pkg::CB_EN] && icfg_reg[0].ctrl[alrm_pkg::CB_LATCH]
      && high_act[0] && !clear_reg;
  endsequence
  property p_latch_hold;
    @(posedge hclk) disable iff (!hresetn) s_latched_quiet |=> high_act[0];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched alarm dropped");
  property p_steady;
    @(posedge hclk) disable iff (!hresetn) |vis_en && !vis_active |=> indicator;
  endproperty
  a_steady: assert property (p_steady) else $error("indicator not steady");
  property p_beep;
    @(posedge hclk) disable iff (!hresetn) |(aud_en & any_act) |=> beeper;
  endproperty
  a_beep: assert property (p_beep) else $error("beeper silent");
endmodule

// >>> verification/alrm_operator.sv
// operator model: reset-alarm key and display selection
`timescale 1ns/1ns
module alrm_operator (
  // clock
  input wire logic hclk,
  // requests from the bench
  input wire logic press,
  input wire logic [1:0] view,
  // pins toward the block
  output logic reset_alarm,
  output logic [1:0] shown_input
);
  logic [2:0] hold_reg = 3'h0;
  // key held 4 cycles so the two-flop synchroniser cannot miss it
  always_ff @(posedge hclk) begin
    if (press) begin
      hold_reg <= 3'h4;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end
  end
  assign reset_alarm = (hold_reg != 3'h0);
  assign shown_input = view;
endmodule

// >>> verification/test_alrm_relay.sv
// self-checking bench for the alarm and relay block
`timescale 1ns/1ns
module test_alrm_relay;
  localparam int FH = 4;
  localparam logic [11:0] ST = alrm_pkg::OFF_STATUS;
  localparam logic [4:0] S_CT = alrm_pkg::SUB_CTRL;
  localparam logic [4:0] S_LO = alrm_pkg::SUB_LOW;
  localparam logic [4:0] S_HI = alrm_pkg::SUB_HIGH;
  localparam logic [4:0] S_DB = alrm_pkg::SUB_DBAND;
  localparam logic [4:0] S_RD = alrm_pkg::SUB_READ;
  localparam logic [31:0] RDG [7] = '{2000, 2001, 1901, 1900, 999, 1099, 1100};
  localparam logic [31:0] STX [7] = '{0, 32'h810, 32'h810, 0, 32'h801, 32'h801, 0};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, reset_alarm, show_alarm_msg, indicator, beeper;
  logic [1:0] shown_input, relay_drive;
  logic press = 1'b0;
  logic [1:0] view = 2'h0;
  logic dphase_rd = 1'b0;
  logic [31:0] exp_q[$];
  logic [15:0] lfsr_state = 16'h719c;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 hclk = ~hclk;

  alrm_relay #(.FLASH_HALF(FH)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .reset_alarm(reset_alarm), .shown_input(shown_input), .show_alarm_msg(show_alarm_msg),
    .indicator(indicator), .beeper(beeper), .relay_drive(relay_drive));

  alrm_operator u_op (.hclk(hclk), .press(press), .view(view), .reset_alarm(reset_alarm),
    .shown_input(shown_input));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [11:0] ia(input int n, input logic [4:0] sub);
    return 12'(n) * alrm_pkg::IN_STRIDE + 12'(sub);
  endfunction

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic wait_rdy();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // one single transfer: address phase, then data phase
  task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  // settle time covers register, alarm state and output stages
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    repeat (4) @(posedge hclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic count_flips(input int cyc, output int ni, output int nm);
    logic pi, pm;
    ni = 0;
    nm = 0;
    pi = indicator;
    pm = show_alarm_msg;
    repeat (cyc) begin
      @(posedge hclk);
      if (indicator !== pi) ni++;
      if (show_alarm_msg !== pm) nm++;
      pi = indicator;
      pm = show_alarm_msg;
    end
  endtask

  // read-data monitor: oldest expectation against each completed read
  always @(posedge hclk) begin
    if (dphase_rd && hreadyout === 1'b1) begin
      chk(hrdata, exp_q.pop_front());
    end
    if (hreadyout === 1'b1) begin
      dphase_rd <= hsel & htrans[1] & ~hwrite;
    end
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    int ni, nm;
    logic [31:0] rv, r1;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ia(0, S_CT), 32'h6);
    rd(ia(0, S_HI), 32'h0098_9680);
    rd(ia(0, S_DB), 32'h0000_2710);
    rd(alrm_pkg::OFF_RLY1, 32'h20);
    rd(ST, 32'h0);
    wr(12'h0f0, 32'h0000_5a5a);
    rd(12'h0f0, 32'h0);
    rd(ia(3, S_RD), 32'h0);
    $display("test defaults done");
    wr(ia(0, S_RD), 32'd1500);
    wr(ia(0, S_LO), 32'd1000);
    wr(ia(0, S_HI), 32'd2000);
    wr(ia(0, S_DB), 32'd100);
    wr(ia(0, S_CT), 32'h7);
    rd(ST, 32'h400);
    wr(ia(0, S_CT), 32'h5);
    foreach (RDG[i]) begin
      wr(ia(0, S_RD), RDG[i]);
      rd(ST, STX[i]);
      chk({31'h0, beeper}, {31'h0, STX[i][11]});
    end
    $display("test thresholds done");
    wr(ia(0, S_CT), 32'hd);
    wr(ia(0, S_RD), 32'd2001);
    wr(ia(0, S_RD), 32'd1500);
    rd(ST, 32'h810);
    wr(alrm_pkg::OFF_CLEAR, 32'h1);
    rd(ST, 32'h0);
    wr(ia(0, S_RD), 32'd999);
    wr(ia(0, S_RD), 32'd1500);
    rd(ST, 32'h801);
    press <= 1'b1;
    @(posedge hclk);
    press <= 1'b0;
    repeat (8) @(posedge hclk);
    rd(ST, 32'h0);
    wr(ia(0, S_RD), 32'd2001);
    wr(ia(0, S_RD), 32'd1500);
    wr(ia(0, S_CT), 32'h8);
    rd(ST, 32'h0);
    $display("test latching done");
    // zero dead band keeps the expected state a pure comparison
    wr(ia(1, S_LO), 32'd1000);
    wr(ia(1, S_HI), 32'd2000);
    wr(ia(1, S_DB), 32'd0);
    wr(ia(1, S_CT), 32'h1);
    wr(alrm_pkg::OFF_RLY2, 32'h1);
    for (int f = 0; f < 3; f++) begin
      for (int h = 0; h < 2; h++) begin
        wr(alrm_pkg::OFF_RLY1, {26'h0, f[1:0], 4'h6});
        wr(ia(1, S_RD), h ? 32'd2001 : 32'd999);
        r1 = ((f == 0 && h == 0) || (f == 1 && h == 1) || f == 2) ? 32'h1 : 32'h0;
        rd(ST, (h ? 32'h20 : 32'h2) | (r1 << 8) | 32'h200);
        chk({30'h0, relay_drive}, {30'h0, 1'b1, r1[0]});
      end
    end
    wr(alrm_pkg::OFF_RLY1, 32'h0);
    wr(alrm_pkg::OFF_RLY2, 32'h0);
    rd(ST, 32'h20);
    wr(ia(1, S_CT), 32'h0);
    $display("test relays done");
    wr(ia(2, S_HI), 32'd2000);
    wr(ia(2, S_RD), 32'd2001);
    wr(ia(2, S_CT), 32'h3);
    view <= 2'h2;
    count_flips(24, ni, nm);
    chk({31'h0, ni >= 4}, 32'h1);
    chk({31'h0, nm >= 4}, 32'h1);
    view <= 2'h0;
    repeat (4) @(posedge hclk);
    count_flips(24, ni, nm);
    chk(nm, 32'h0);
    wr(ia(2, S_CT), 32'h0);
    $display("test indication done");
    wr(ia(3, S_LO), 32'h4000);
    wr(ia(3, S_HI), 32'hc000);
    wr(ia(3, S_DB), 32'h0);
    wr(ia(3, S_CT), 32'h1);
    for (int k = 0; k < 12; k++) begin
      lfsr_state = lfsr_next(lfsr_state);
      rv = {16'h0, lfsr_state};
      wr(ia(3, S_RD), rv);
      rd(ST, (rv < 32'h4000 ? 32'h8 : 32'h0) | (rv > 32'hc000 ? 32'h80 : 32'h0));
    end
    $display("test random done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ia(3, S_CT), 32'h6);
    rd(ST, 32'h0);
    $display("test second reset done");
    complete_run();
  end
endmodule
